// ==== clock_gen_pkg.sv ====
// Package with register map, field positions and timing for the clock generation unit
package clock_gen_pkg;

  // Register word indexes (address bits 4:2), one aligned word each
  localparam logic [2:0] ADDR_CONTROL    = 3'h0;
  localparam logic [2:0] ADDR_MULTIPLIER = 3'h1;
  localparam logic [2:0] ADDR_TRIM       = 3'h2;
  localparam logic [2:0] ADDR_DIVIDER    = 3'h3;
  localparam logic [2:0] ADDR_STAGE      = 3'h4;
  localparam logic [2:0] ADDR_CONFIG     = 3'h5;

  // Control register field positions
  localparam int BIT_IRQ_EN    = 7;
  localparam int BIT_LOSS      = 6;
  localparam int BIT_MON_EN    = 5;
  localparam int BIT_SELECT    = 4;
  localparam int BIT_INT_EN    = 3;
  localparam int BIT_INT_STB   = 2;
  localparam int BIT_EXT_EN    = 1;
  localparam int BIT_EXT_STB   = 0;

  // Configuration register field positions
  localparam int BIT_OSC_STOP  = 0;

  // Reset values
  localparam logic [6:0] MULT_RESET = 7'h15;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [3:0] DIV_MAX    = 4'h9;

  // External startup delay in external clock cycles
  localparam int EXT_START_CYCLES = 4096;
  localparam int EXT_CNT_W        = 13;

  // Bus request bundle
  typedef struct packed {
    logic       read;
    logic       write;
    logic [4:0] address;
    logic [7:0] writedata;
  } bus_req_type;

endpackage : clock_gen_pkg

// ==== clock_generator_control.sv ====
// Control and status logic of the clock generation unit with an Avalon-MM slave
// How it works
// RULE_01: Loss flag sets when monitor sees either clock stop while monitoring on.
// RULE_02: Loss flag clears by read-while-set then write zero; forced clear if off.
// RULE_03: Monitor enable sets only after both generators enabled and stable a cycle.
// RULE_04: Monitor enable held set while the loss flag is set.
// RULE_05: Monitor enable forced clear on any generator off, stop without oscillator, or reset.
// RULE_06: Output clock follows external clock when select is one, else internal.
// RULE_07: Select sets after external ready one cycle, clears after internal ready.
// RULE_08: Select forced set on internal loss or internal generator off.
// RULE_09: Select forced clear on external loss, external generator off, or reset.
// RULE_10: Internal enable clears only after select set and monitor clear a cycle.
// RULE_11: Internal enable forced set while monitoring, select zero, or reset.
// RULE_12: Internal stable rises when the internal clock is judged near target.
// RULE_13: Internal stable clears on loss, disable, multiplier/trim write, stop without oscillator, reset.
// RULE_14: External enable clears on a write only while select and monitor are clear.
// RULE_15: External enable forced set while monitoring or selected; reset clears.
// RULE_16: External stable sets after 4096 external clock cycles from enabling.
// RULE_17: External stable clears on loss, disable, stop without oscillator, reset.
// RULE_18: Multiplier seven bits, zero acts as one, reset loads decimal 21.
// RULE_19: Multiplier and trim writes ignored while monitoring is enabled.
// RULE_20: Trim is eight bits, reset loads midpoint 0x80.
// RULE_21: Divider count saturates at 9 and follows the loop filter when enabled.
// RULE_22: Stage count writes blocked while internal generator enabled; reset keeps it, but the stage_count_out port resets to 0x00.
// RULE_23: Interrupt request while both interrupt enable and loss flag are set.
`timescale 1ns/1ps
module clock_generator_control
  import clock_gen_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        stop_mode_in,
  input  wire logic        internal_lost_in,
  input  wire logic        external_lost_in,
  input  wire logic        internal_locked_in,
  input  wire logic        external_clock_edge_in,
  input  wire logic [3:0]  filter_divider_in,
  input  wire logic [7:0]  filter_stage_in,
  output logic             select_external_out,
  output logic             internal_gen_enable_out,
  output logic             external_gen_enable_out,
  output logic [6:0]       multiplier_factor_out,
  output logic [7:0]       trim_factor_out,
  output logic [3:0]       divider_count_out,
  output logic [7:0]       stage_count_out,
  output logic             clock_monitor_irq_out
);

  // Bus handshake state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_type;

  bus_state_type bus_state;
  bus_req_type   req;
  logic [6:0]  multiplier_factor;
  logic [7:0]  trim_factor;
  logic [3:0]  divider_count;
  logic [7:0]  stage_count;
  logic        osc_in_stop_enable;
  logic        monitor_irq_enable;
  logic        clock_loss_flag;
  logic        monitor_enable;
  logic        clock_select;
  logic        internal_gen_enable;
  logic        internal_stable;
  logic        external_gen_enable;
  logic        external_stable;
  logic        loss_seen;
  logic        mon_prev;
  logic        ext_ready_prev;
  logic        int_ready_prev;
  logic        mon_clear_prev;
  logic [EXT_CNT_W-1:0] ext_count;
  logic        stopped;
  logic        acc;
  logic        wr_ctl;
  logic        wr_mult;
  logic        wr_trim;
  logic [7:0]  control_view;
  logic [7:0]  next_read;

  // Request bundle and accept strobe; one cycle wait per access
  assign req = '{read: avs_read_in, write: avs_write_in,
                 address: avs_address_in, writedata: avs_writedata_in[7:0]};
  assign acc     = (bus_state == BUS_IDLE) && (req.read || req.write);
  assign wr_ctl  = acc && req.write && avs_byteenable_in[0] && req.address[4:2] == ADDR_CONTROL;
  assign wr_mult = acc && req.write && avs_byteenable_in[0] && req.address[4:2] == ADDR_MULTIPLIER
                   && !monitor_enable; // RULE_19
  assign wr_trim = acc && req.write && avs_byteenable_in[0] && req.address[4:2] == ADDR_TRIM
                   && !monitor_enable; // RULE_19
  assign stopped = stop_mode_in && !osc_in_stop_enable;

  assign control_view = {monitor_irq_enable, clock_loss_flag, monitor_enable, clock_select,
                         internal_gen_enable, internal_stable, external_gen_enable,
                         external_stable};

  // Read mux, unmapped addresses read zero
  always_comb begin
    next_read = 8'h00;
    unique case (req.address[4:2])
      ADDR_CONTROL:    next_read = control_view;
      ADDR_MULTIPLIER: next_read = {1'b0, multiplier_factor};
      ADDR_TRIM:       next_read = trim_factor;
      ADDR_DIVIDER:    next_read = {4'h0, divider_count};
      ADDR_STAGE:      next_read = stage_count;
      ADDR_CONFIG:     next_read = {7'h00, osc_in_stop_enable};
      default:         next_read = 8'h00;
    endcase
  end

  // Bus slave: waitrequest high until the data cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_state           <= BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      unique case (bus_state)
        BUS_IDLE: begin
          if (req.read || req.write) begin
            bus_state           <= BUS_DONE;
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= {24'h00_0000, next_read};
          end
        end
        BUS_DONE: begin
          bus_state           <= BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // One-bus-cycle history of the interlock conditions
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mon_prev       <= 1'b0;
      ext_ready_prev <= 1'b0;
      int_ready_prev <= 1'b0;
      mon_clear_prev <= 1'b0;
    end else begin
      mon_prev       <= internal_gen_enable && internal_stable
                        && external_gen_enable && external_stable; // RULE_03
      ext_ready_prev <= external_gen_enable && external_stable; // RULE_07
      int_ready_prev <= internal_gen_enable && internal_stable; // RULE_07
      mon_clear_prev <= !monitor_enable;
    end
  end

  // Loss flag; a fresh loss beats a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clock_loss_flag <= 1'b0;
      loss_seen       <= 1'b0;
    end else if (!monitor_enable) begin
      clock_loss_flag <= 1'b0; // RULE_02
      loss_seen       <= 1'b0;
    end else if (internal_lost_in || external_lost_in) begin
      clock_loss_flag <= 1'b1; // RULE_01
    end else begin
      if (acc && req.read && req.address[4:2] == ADDR_CONTROL && clock_loss_flag)
        loss_seen <= 1'b1;
      if (wr_ctl && loss_seen && !req.writedata[BIT_LOSS]) begin
        clock_loss_flag <= 1'b0; // RULE_02
        loss_seen       <= 1'b0;
      end
    end
  end

  // Monitor enable and its interrupt enable
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      monitor_enable     <= 1'b0;
      monitor_irq_enable <= 1'b0;
    end else begin
      if (!internal_gen_enable || !external_gen_enable || stopped)
        monitor_enable <= 1'b0; // RULE_05
      else if (clock_loss_flag)
        monitor_enable <= 1'b1; // RULE_04
      else if (wr_ctl && req.writedata[BIT_MON_EN] && mon_prev)
        monitor_enable <= 1'b1; // RULE_03
      else if (wr_ctl && !req.writedata[BIT_MON_EN])
        monitor_enable <= 1'b0;
      // Interrupt enable only sticks once monitoring is already on
      if (!monitor_enable)
        monitor_irq_enable <= 1'b0;
      else if (wr_ctl)
        monitor_irq_enable <= req.writedata[BIT_IRQ_EN];
    end
  end

  // Clock select with forced transitions
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clock_select <= 1'b0;
    end else if ((monitor_enable && external_lost_in) || !external_gen_enable) begin
      clock_select <= 1'b0; // RULE_09
    end else if ((monitor_enable && internal_lost_in) || !internal_gen_enable) begin
      clock_select <= 1'b1; // RULE_08
    end else if (wr_ctl) begin
      if (req.writedata[BIT_SELECT] && ext_ready_prev)
        clock_select <= 1'b1; // RULE_07
      else if (!req.writedata[BIT_SELECT] && int_ready_prev)
        clock_select <= 1'b0; // RULE_07
    end
  end

  // Generator enables
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      internal_gen_enable <= 1'b1; // RULE_11
      external_gen_enable <= 1'b0; // RULE_15
    end else begin
      if (monitor_enable || !clock_select)
        internal_gen_enable <= 1'b1; // RULE_11
      else if (wr_ctl && !req.writedata[BIT_INT_EN] && mon_clear_prev)
        internal_gen_enable <= 1'b0; // RULE_10
      else if (wr_ctl)
        internal_gen_enable <= 1'b1;
      if (monitor_enable || clock_select)
        external_gen_enable <= 1'b1; // RULE_15
      else if (wr_ctl)
        external_gen_enable <= req.writedata[BIT_EXT_EN]; // RULE_14
    end
  end

  // Internal stable follows the lock judgement of the loop filter
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      internal_stable <= 1'b0;
    end else if ((monitor_enable && internal_lost_in) || !internal_gen_enable
                 || wr_mult || wr_trim || stopped) begin
      internal_stable <= 1'b0; // RULE_13
    end else begin
      internal_stable <= internal_locked_in; // RULE_12
    end
  end

  // External startup counter, counts sampled external clock edges
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_count       <= '0;
      external_stable <= 1'b0;
    end else if ((monitor_enable && external_lost_in) || !external_gen_enable || stopped) begin
      ext_count       <= '0; // RULE_17
      external_stable <= 1'b0;
    end else if (ext_count == EXT_CNT_W'(EXT_START_CYCLES)) begin
      external_stable <= 1'b1; // RULE_16
    end else if (external_clock_edge_in) begin
      ext_count <= ext_count + EXT_CNT_W'(1);
    end
  end

  // Multiplier, trim and stop option registers
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      multiplier_factor  <= MULT_RESET; // RULE_18
      trim_factor        <= TRIM_RESET; // RULE_20
      osc_in_stop_enable <= 1'b0;
    end else begin
      if (wr_mult)
        multiplier_factor <= req.writedata[6:0];
      if (wr_trim)
        trim_factor <= req.writedata;
      if (acc && req.write && req.address[4:2] == ADDR_CONFIG && avs_byteenable_in[0])
        osc_in_stop_enable <= req.writedata[BIT_OSC_STOP];
    end
  end

  // Divider count; reset parks it at the saturation value
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      divider_count <= DIV_MAX;
    end else if (internal_gen_enable) begin
      divider_count <= (filter_divider_in > DIV_MAX) ? DIV_MAX : filter_divider_in; // RULE_21
    end else if (acc && req.write && avs_byteenable_in[0]
                 && req.address[4:2] == ADDR_DIVIDER) begin
      divider_count <= (req.writedata[3:0] > DIV_MAX) ? DIV_MAX : req.writedata[3:0];
    end
  end

  // Stage count has no reset: the oscillator runs on through reset, and the
  // internal enable, set during reset, keeps the loop filter in charge of it
  always_ff @(posedge sys_clk_in) begin
    if (internal_gen_enable)
      stage_count <= filter_stage_in; // RULE_22
    else if (acc && req.write && avs_byteenable_in[0] && req.address[4:2] == ADDR_STAGE)
      stage_count <= req.writedata; // RULE_22
  end

  // Registered outputs
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      select_external_out     <= 1'b0;
      internal_gen_enable_out <= 1'b1;
      external_gen_enable_out <= 1'b0;
      multiplier_factor_out   <= MULT_RESET;
      trim_factor_out         <= TRIM_RESET;
      divider_count_out       <= DIV_MAX;
      stage_count_out         <= 8'h00;
      clock_monitor_irq_out   <= 1'b0;
    end else begin
      select_external_out     <= clock_select; // RULE_06
      internal_gen_enable_out <= internal_gen_enable;
      external_gen_enable_out <= external_gen_enable;
      multiplier_factor_out   <= (multiplier_factor == 7'h00) ? 7'h01 : multiplier_factor; // RULE_18
      trim_factor_out         <= trim_factor;
      divider_count_out       <= divider_count;
      stage_count_out         <= stage_count;
      clock_monitor_irq_out   <= monitor_irq_enable && clock_loss_flag; // RULE_23
    end
  end

  // Assertions
  AST_LOSS_SET: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_01
    monitor_enable && (internal_lost_in || external_lost_in) && internal_gen_enable
    && external_gen_enable && !stopped |=> clock_loss_flag)
    else $error("loss flag not set");
  AST_LOSS_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_02
    !monitor_enable |=> !clock_loss_flag)
    else $error("loss flag kept without monitor");
  AST_MON_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_04
    clock_loss_flag && internal_gen_enable && external_gen_enable && !stopped |=> monitor_enable)
    else $error("monitor dropped with loss flag");
  AST_MON_FORCE: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_05
    !internal_gen_enable || !external_gen_enable || stopped |=> !monitor_enable)
    else $error("monitor not forced clear");
  AST_SEL_OUT: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_06
    ##1 select_external_out == $past(clock_select))
    else $error("output select mismatch");
  AST_INT_EN: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_11
    monitor_enable || !clock_select |=> internal_gen_enable)
    else $error("internal enable not forced");
  AST_EXT_EN: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_15
    monitor_enable || clock_select |=> external_gen_enable)
    else $error("external enable not forced");
  AST_MULT_LOCK: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_19
    monitor_enable |=> $stable(multiplier_factor) && $stable(trim_factor))
    else $error("locked register changed");
  AST_IRQ: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_23
    monitor_irq_enable && clock_loss_flag |=> clock_monitor_irq_out)
    else $error("interrupt not raised");
  AST_DIV_MAX: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_21
    divider_count <= DIV_MAX)
    else $error("divider above nine");

  // Forced select transitions on a detected loss, stable clears on loss, multiplier/trim write or disable
  AST_SEL_INT_LOSS: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_08
    monitor_enable && internal_lost_in && !external_lost_in && external_gen_enable
    |=> clock_select)
    else $error("select not forced to external");
  AST_EXT_LOSS: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_09
    monitor_enable && external_lost_in |=> !clock_select && !external_stable)
    else $error("select or external stable kept after loss");
  AST_INT_STB_CLR: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_13
    wr_mult || wr_trim || !internal_gen_enable |=> !internal_stable)
    else $error("internal stable not cleared");

  // External stable never rises before the startup count is complete
  AST_EXT_STB: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_16
    !external_stable && ext_count != EXT_CNT_W'(EXT_START_CYCLES) |=> !external_stable)
    else $error("external stable too early");

  // Loop filter owns the stage count while the internal generator runs
  AST_STAGE_FOLLOW: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // RULE_22
    internal_gen_enable |=> stage_count == $past(filter_stage_in))
    else $error("stage count not from loop filter");

endmodule : clock_generator_control

// ==== test_clock_generator_control.sv ====
// Self-checking testbench for the clock generator control block
`timescale 1ns/1ps
module test_clock_generator_control;
  import clock_gen_pkg::*;

  logic        sys_clk_in, rst_b_in, avs_read_in, avs_write_in;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0]  avs_byteenable_in, filter_divider_in, divider_count_out;
  logic        avs_waitrequest_out, stop_mode_in, internal_lost_in, external_lost_in;
  logic        internal_locked_in, external_clock_edge_in, select_external_out;
  logic        internal_gen_enable_out, external_gen_enable_out, clock_monitor_irq_out;
  logic [7:0]  filter_stage_in, trim_factor_out, stage_count_out, r;
  logic [6:0]  multiplier_factor_out, m;
  logic [31:0] seed;
  int          n_errors, check_count;

  clock_generator_control uut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .stop_mode_in(stop_mode_in), .internal_lost_in(internal_lost_in),
    .external_lost_in(external_lost_in), .internal_locked_in(internal_locked_in),
    .external_clock_edge_in(external_clock_edge_in), .filter_divider_in(filter_divider_in),
    .filter_stage_in(filter_stage_in), .select_external_out(select_external_out),
    .internal_gen_enable_out(internal_gen_enable_out),
    .external_gen_enable_out(external_gen_enable_out),
    .multiplier_factor_out(multiplier_factor_out), .trim_factor_out(trim_factor_out),
    .divider_count_out(divider_count_out), .stage_count_out(stage_count_out),
    .clock_monitor_irq_out(clock_monitor_irq_out)
  );

  // Free-running system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // Repeatable pseudo-random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Multiplier of zero behaves as one
  function automatic logic [6:0] eff_mult(input logic [6:0] v);
    return (v == 7'h00) ? 7'h01 : v;
  endfunction : eff_mult

  // Divider codes above nine saturate
  function automatic logic [3:0] eff_div(input logic [3:0] v);
    return (v > 4'h9) ? 4'h9 : v;
  endfunction : eff_div

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon transfer; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    avs_address_in   <= adr;
    avs_writedata_in <= {24'h0, wd};
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) n_errors++;
    rd = avs_readdata_out[7:0];
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] adr, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, adr, d, x);
  endtask : wr

  // Read and keep only the bits picked by the mask
  task automatic rdm(input logic [4:0] adr, input logic [7:0] mask, output logic [7:0] v);
    bus(1'b0, adr, 8'h00, v);
    v = v & mask;
  endtask : rdm

  // Outputs lag internal state by a cycle; sampled at the edge, before it acts
  task automatic settle();
    repeat (3) @(posedge sys_clk_in);
  endtask : settle

  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      external_clock_edge_in <= 1'b1;
      @(posedge sys_clk_in);
      external_clock_edge_in <= 1'b0;
    end
  endtask : ext_edges

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // Hang guard, well beyond the expected run of about 8500 cycles
  initial begin
    #(30000 * 8);
    n_errors++;
    conclude();
  end

  initial begin
    seed = 32'h3444c7c9;
    n_errors = 0;
    check_count = 0;
    {rst_b_in, avs_read_in, avs_write_in, stop_mode_in} = 4'h0;
    {internal_lost_in, external_lost_in, internal_locked_in, external_clock_edge_in} = 4'h0;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'h1;
    filter_divider_in = 4'hc;
    filter_stage_in = 8'h5a;
    repeat (16) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    #1;
    check(multiplier_factor_out, MULT_RESET);
    check(trim_factor_out, TRIM_RESET);
    check(select_external_out, 1'b0);
    check(internal_gen_enable_out, 1'b1);
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h08);
    // Multiplier and trim: corner values then random ones
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'(rnd());
      wr(ADDR_MULTIPLIER << 2, {1'b0, m});
      r = (i == 0) ? 8'hff : 8'(rnd());
      wr(ADDR_TRIM << 2, r);
      settle();
      check(multiplier_factor_out, eff_mult(m));
      check(trim_factor_out, r);
    end
    internal_locked_in <= 1'b1;
    filter_divider_in <= 4'(rnd());
    filter_stage_in <= 8'(rnd());
    settle();
    check(divider_count_out, eff_div(filter_divider_in));
    check(stage_count_out, filter_stage_in);
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h0c);
    // Select and monitor refused before the external side is stable
    wr(ADDR_CONTROL << 2, 8'h1a);
    wr(ADDR_CONTROL << 2, 8'h2a);
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h0e);
    ext_edges(4095);
    settle();
    rdm(ADDR_CONTROL << 2, 8'h01, r);
    check(r, 8'h00);
    ext_edges(1);
    settle();
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h0f);
    wr(ADDR_CONTROL << 2, 8'h1a);
    settle();
    check(select_external_out, 1'b1);
    wr(ADDR_CONTROL << 2, 8'h18);
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h1f);
    check(external_gen_enable_out, 1'b1);
    // Internal generator off: stable drops, divider and stage become writable
    wr(ADDR_CONTROL << 2, 8'h12);
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h13);
    check(internal_gen_enable_out, 1'b0);
    wr(ADDR_DIVIDER << 2, 8'h03);
    settle();
    check(divider_count_out, 4'h3);
    wr(ADDR_DIVIDER << 2, 8'h0c);
    r = 8'(rnd());
    wr(ADDR_STAGE << 2, r);
    settle();
    check(divider_count_out, 4'h9);
    check(stage_count_out, r);
    wr(ADDR_CONTROL << 2, 8'h1a);
    wr(ADDR_STAGE << 2, ~filter_stage_in);
    settle();
    check(stage_count_out, filter_stage_in);
    wr(ADDR_CONTROL << 2, 8'h0a);
    wr(ADDR_CONTROL << 2, 8'h02);
    settle();
    check(select_external_out, 1'b0);
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h0f);
    // Monitoring on: multiplier locked, interrupt enabled
    wr(ADDR_CONTROL << 2, 8'h2a);
    wr(ADDR_CONTROL << 2, 8'haa);
    m = multiplier_factor_out;
    wr(ADDR_MULTIPLIER << 2, 8'h33);
    settle();
    check(multiplier_factor_out, m);
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'haf);
    // Internal loss while clear is attempted: loss wins, monitor held
    internal_lost_in <= 1'b1;
    settle();
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'hfb);
    check(clock_monitor_irq_out, 1'b1);
    wr(ADDR_CONTROL << 2, 8'h8a);
    rdm(ADDR_CONTROL << 2, 8'hfb, r);
    check(r, 8'hfb);
    internal_lost_in <= 1'b0;
    settle();
    rdm(ADDR_CONTROL << 2, 8'h40, r);
    check(r, 8'h40);
    wr(ADDR_CONTROL << 2, 8'hba);
    settle();
    check(clock_monitor_irq_out, 1'b0);
    rdm(ADDR_CONTROL << 2, 8'hfb, r);
    check(r, 8'hbb);
    // External loss forces select back to internal
    external_lost_in <= 1'b1;
    settle();
    rdm(ADDR_CONTROL << 2, 8'hfb, r);
    check(r, 8'hea);
    check(select_external_out, 1'b0);
    external_lost_in <= 1'b0;
    settle();
    rdm(ADDR_CONTROL << 2, 8'h40, r);
    wr(ADDR_CONTROL << 2, 8'haa);
    rdm(ADDR_CONTROL << 2, 8'hfa, r);
    check(r, 8'haa);
    // Stop with oscillator off in stop clears monitor and stable bits
    stop_mode_in <= 1'b1;
    settle();
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h0a);
    stop_mode_in <= 1'b0;
    rdm(ADDR_CONFIG << 2, 8'hff, r);
    check(r, 8'h00);
    rdm(5'h18, 8'hff, r);
    check(r, 8'h00);
    // Oscillator kept in stop: internal stable survives stop mode
    wr(ADDR_CONFIG << 2, 8'h01);
    rdm(ADDR_CONFIG << 2, 8'hff, r);
    check(r, 8'h01);
    stop_mode_in <= 1'b1;
    settle();
    rdm(ADDR_CONTROL << 2, 8'hff, r);
    check(r, 8'h0e);
    stop_mode_in <= 1'b0;
    // A write without the low byte lane leaves trim alone
    r = trim_factor_out;
    avs_byteenable_in <= 4'h2;
    wr(ADDR_TRIM << 2, ~r);
    avs_byteenable_in <= 4'h1;
    settle();
    check(trim_factor_out, r);
    conclude();
  end
endmodule : test_clock_generator_control
